// ==== dv/gpio_pin_model.sv ====
`timescale 1ns/1ps
// the world outside the pads: bank drivers, pulls and outside sources
module gpio_pin_model (
	input  wire gpio_port_pkg::pad_ctl_s [6:0] pad_i,
	input  wire logic [6:0][7:0]              ext_i,
	output logic      [6:0][7:0]              pin_o
);
	// a driven pin shows the bank, an undriven one its pull, else the
	// outside source, which holds its level until the bench moves it
	always_comb begin
		for (int p = 0; p < 7; p++) begin
			for (int b = 0; b < 8; b++) begin
				pin_o[p][b] = pad_i[p].oe[b] ? pad_i[p].out[b] :
					pad_i[p].pur[b] ? 1'b1 :
					pad_i[p].pdr[b] ? 1'b0 : ext_i[p][b];
			end
		end
	end
endmodule

// ==== dv/gpio_port_bank_chk.sv ====
`timescale 1ns/1ps
// watches port A access timing and pad outputs, plus the reset pad controls of ports A, B and C
module gpio_port_bank_chk (
	input wire logic                          clk_i,
	input wire logic                          rstn_i,
	input wire gpio_port_pkg::acc_req_s [6:0] acc_req_i,
	input wire gpio_port_pkg::acc_rsp_s [6:0] acc_rsp_o,
	input wire gpio_port_pkg::pad_ctl_s [6:0] pad_o,
	input wire logic [6:0]                    port_irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	// port A request alone; all ports share one body
	wire gpio_port_pkg::acc_req_s q = acc_req_i[0];
	wire logic                    rd = q.valid && !q.write;
	req_answer_a: assert property (q.valid |=> acc_rsp_o[0].valid)
		else $error("request got no answer");
	no_answer_a: assert property (!q.valid |=> !acc_rsp_o[0].valid)
		else $error("answer without request");
	read_mask_a: assert property (rd && q.target == gpio_port_pkg::SEL_DATA
		|=> (acc_rsp_o[0].rdata & ~$past(q.addr_mask)) == 8'h00)
		else $error("unmasked data bit read non-zero");
	line_status_a: assert property (rd && q.target == gpio_port_pkg::SEL_MIS
		|=> port_irq_o[0] == |acc_rsp_o[0].rdata)
		else $error("port line disagrees with masked status");
	drive_den_a: assert property ((pad_o[0].oe & ~pad_o[0].den) == 8'h00)
		else $error("pin driven without digital enable");
	open_drain_a: assert property ((pad_o[0].out & pad_o[0].odr) == 8'h00)
		else $error("open drain pin drives high");
	write_zero_a: assert property (q.valid && q.write
		|=> acc_rsp_o[0].rdata == 8'h00)
		else $error("write answer carries data");
	// reset itself is the cause here, so this one is never disabled
	reset_pads_a: assert property (disable iff (1'b0) !rstn_i |=>
		pad_o[0].oe == 8'h00 && pad_o[1].pur == 8'h80 && pad_o[2].den == 8'h0F)
		else $error("pad controls not at reset defaults");
	cover property (rd && q.target == gpio_port_pkg::SEL_MIS ##1 port_irq_o[0]);
	cover property (q.valid && q.write && q.target == gpio_port_pkg::SEL_DATA);
	cover property (rd && q.target == gpio_port_pkg::SEL_PID);
endmodule

bind gpio_port_bank gpio_port_bank_chk chk (.clk_i, .rstn_i, .acc_req_i,
	.acc_rsp_o, .pad_o, .port_irq_o);

// ==== dv/gpio_port_bank_tb_top.sv ====
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
module gpio_port_bank_tb_top;
	logic                          clk = 1'b0; // 40 MHz system clock
	logic                          rstn = 1'b0; // held low from time zero
	gpio_port_pkg::acc_req_s [6:0] req = '0; // one access port per port
	gpio_port_pkg::acc_rsp_s [6:0] rsp;
	gpio_port_pkg::pad_ctl_s [6:0] pad;
	logic [6:0][7:0]               pin;
	logic [6:0][7:0]               ext = '0; // outside source levels
	logic [6:0]                    irq;
	gpio_port_pkg::periph_s  [6:0] per = '0; // peripheral drive
	logic [6:0][7:0]               pin_in; // peripheral input view
	logic                          trig;
	logic [7:0]                    rd; // last read answer
	int fail_count = 0, checked = 0, cyc = 0, trig_n = 0;
	always #12.5 clk = ~clk;
	// peripherals stay idle until the closing alternate-drive check
	gpio_port_bank uut (.clk_i(clk), .rstn_i(rstn), .acc_req_i(req),
		.acc_rsp_o(rsp), .pad_in_i(pin), .pad_o(pad), .periph_i(per),
		.periph_in_o(pin_in), .port_irq_o(irq),
		.converter_trigger_o(trig));
	gpio_pin_model pins (.pad_i(pad), .ext_i(ext), .pin_o(pin));
	task automatic chk(input string n, input logic [7:0] s, e);
		checked++;
		if (s !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask
	// request set after a falling edge, held over one rising edge
	task automatic acc(input int p, input logic w,
		input gpio_port_pkg::reg_sel_e t, input logic [7:0] m, d);
		@(negedge clk);
		req[p] = '{1'b1, w, t, m, d};
		@(negedge clk);
		req[p].valid = 1'b0;
		chk("answer", {7'h00, rsp[p].valid}, 8'h01);
		rd = rsp[p].rdata;
	endtask
	task automatic wr(input int p, input gpio_port_pkg::reg_sel_e t,
		input logic [7:0] m, d);
		acc(p, 1'b1, t, m, d);
	endtask
	task automatic rdc(input int p, input gpio_port_pkg::reg_sel_e t,
		input logic [7:0] m, e);
		acc(p, 1'b0, t, m, 8'h00);
		chk(t.name(), rd, e);
	endtask
	task automatic complete_run;
		if (fail_count == 0 && checked > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	// hang guard, well above the ~165 cycles the sequence needs
	always @(posedge clk) begin
		cyc++;
		if (trig === 1'b1) trig_n++;
		if (cyc == 3000) begin
			fail_count++;
			complete_run;
		end
	end
	initial begin
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk); // settle after reset
		for (int p = 0; p < 7; p++) begin
			rd = p == 1 ? 8'h80 : p == 2 ? 8'h0F : 8'h00;
			rdc(p, gpio_port_pkg::SEL_AFSEL, 8'hFF, rd);
		end
		wr(0, gpio_port_pkg::SEL_DEN, 8'hFF, 8'hFF);
		wr(0, gpio_port_pkg::SEL_DIR, 8'hFF, 8'hFF);
		wr(0, gpio_port_pkg::SEL_DATA, 8'hFF, 8'hFF);
		wr(0, gpio_port_pkg::SEL_DATA, 8'h26, 8'hEB);
		rdc(0, gpio_port_pkg::SEL_DATA, 8'hC4, 8'hC0);
		rdc(0, gpio_port_pkg::SEL_DATA, 8'hFF, 8'hFB);
		chk("pad out", pad[0].out, 8'hFB);
		wr(0, gpio_port_pkg::SEL_ODR, 8'hFF, 8'h01);
		@(negedge clk);
		chk("open drain", pad[0].out, 8'hFA);
		wr(0, gpio_port_pkg::SEL_DIR, 8'hFF, 8'h00);
		ext[0] = 8'h5A;
		repeat (4) @(negedge clk);
		rdc(0, gpio_port_pkg::SEL_DATA, 8'hFF, 8'h5A);
		// trigger settings written while still masked
		wr(0, gpio_port_pkg::SEL_IEV, 8'hFF, 8'hFF);
		wr(0, gpio_port_pkg::SEL_ICR, 8'hFF, 8'hFF); // stale edges
		wr(0, gpio_port_pkg::SEL_IM, 8'hFF, 8'h01);
		ext[0] = 8'h5B;
		repeat (5) @(negedge clk);
		chk("irq", {7'h00, irq[0]}, 8'h01);
		ext[0] = 8'h5A; // falling edge must not count
		repeat (5) @(negedge clk);
		wr(0, gpio_port_pkg::SEL_ICR, 8'hFF, 8'h00);
		rdc(0, gpio_port_pkg::SEL_RIS, 8'hFF, 8'h01);
		wr(0, gpio_port_pkg::SEL_ICR, 8'hFF, 8'h01);
		rdc(0, gpio_port_pkg::SEL_RIS, 8'hFF, 8'h00);
		wr(0, gpio_port_pkg::SEL_IS, 8'hFF, 8'h02); // bit 1 not enabled
		repeat (3) @(negedge clk);
		rdc(0, gpio_port_pkg::SEL_RIS, 8'hFF, 8'h02);
		rdc(0, gpio_port_pkg::SEL_MIS, 8'hFF, 8'h00);
		wr(0, gpio_port_pkg::SEL_IM, 8'hFF, 8'h00);
		wr(0, gpio_port_pkg::SEL_IBE, 8'hFF, 8'h04);
		ext[0] = 8'h5E;
		repeat (5) @(negedge clk);
		wr(0, gpio_port_pkg::SEL_ICR, 8'hFF, 8'h04);
		ext[0] = 8'h5A;
		repeat (5) @(negedge clk);
		rdc(0, gpio_port_pkg::SEL_RIS, 8'hFF, 8'h06);
		wr(1, gpio_port_pkg::SEL_IEV, 8'hFF, 8'h10);
		wr(1, gpio_port_pkg::SEL_IM, 8'hFF, 8'h10);
		trig_n = 0;
		ext[1] = 8'h10;
		repeat (5) @(negedge clk);
		chk("trigger", trig_n[7:0], 8'h01);
		chk("irq b", {7'h00, irq[1]}, 8'h01);
		wr(1, gpio_port_pkg::SEL_AFSEL, 8'hFF, 8'h00);
		rdc(1, gpio_port_pkg::SEL_AFSEL, 8'hFF, 8'h80);
		wr(1, gpio_port_pkg::SEL_LOCK, 8'hFF, 8'hA5);
		wr(1, gpio_port_pkg::SEL_CR, 8'hFF, 8'hFF);
		wr(1, gpio_port_pkg::SEL_AFSEL, 8'hFF, 8'h00);
		rdc(1, gpio_port_pkg::SEL_AFSEL, 8'hFF, 8'h00);
		wr(6, gpio_port_pkg::SEL_DEN, 8'hFF, 8'hFF);
		@(negedge clk);
		chk("no pad", pad[6].den, 8'h03);
		for (int i = 0; i < 8; i++) begin
			rd = 8'(`GPIO_PERIPH_ID >> (8 * i));
			rdc(0, gpio_port_pkg::SEL_PID, 8'(i), rd);
		end
		for (int i = 0; i < 4; i++) begin
			rd = 8'(`GPIO_CELL_ID >> (8 * i));
			rdc(0, gpio_port_pkg::SEL_CID, 8'(i), rd);
		end
		rstn = 1'b0;
		repeat (3) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		rdc(1, gpio_port_pkg::SEL_AFSEL, 8'hFF, 8'h80);
		chk("den after reset", pad[0].den, 8'h00);
		chk("periph in", pin_in[1], 8'h80);
		per[1] = '{8'h00, 8'h80}; // peripheral takes its debug pin
		@(negedge clk);
		chk("af drive", pad[1].oe, 8'h80);
		complete_run;
	end
endmodule

// ==== rtl/gpio_port_bank.sv ====
`timescale 1ns/1ps
`include "gpio_port_regs.svh"
// Behaviour
// - ordinary pins reset undriven, controls cleared except 2 mA drive set
// - debug pins reset with alternate, enable, pull-up
// - any reset restores both pin groups
// - seven identical port instances, own registers
// - direction 0 captures pin, 1 drives data
// - data decoded over 256 words, mask
// - write changes only mask-selected data bits
// - read returns zero for unselected bits
// - all pin conditions combine into one line
// - edge condition stays latched until cleared
// - sense, both-edges, polarity choose the condition
// - mask bit gates each pin onto line
// - raw shows all, masked shows allowed ones
// - clear write one clears, zero keeps
// - unmasked port B pin 4 pulses converter per edge, holds it high on a level
// - alternate bit hands pin to peripheral
// - protected alternate writes need unlock and commit
// - pad settings presented to the pad cells
// - eight peripheral and four cell ident registers
// - pins without pad ignore writes

// one port: registers, pad muxing, interrupts
module gpio_port_core #(
	parameter int PORT_IDX = 0
) (
	input  wire logic                   clk_i,
	input  wire logic                   rstn_i,
	input  wire gpio_port_pkg::acc_req_s req_i,
	output gpio_port_pkg::acc_rsp_s      rsp_o,
	input  wire logic [7:0]             pad_in_i,
	output gpio_port_pkg::pad_ctl_s      pad_o,
	input  wire gpio_port_pkg::periph_s  periph_i,
	output logic      [7:0]             periph_in_o,
	output logic                        irq_o,
	output logic                        trig_o
);
	// fixed per-port masks
	localparam logic [7:0] DBG  = gpio_port_pkg::debug_mask_of(PORT_IDX);
	localparam logic [7:0] PRES = gpio_port_pkg::present_mask_of(PORT_IDX);
	// only port B pin 4 may fire the converter trigger
	localparam logic [7:0] TRIG = (PORT_IDX == `GPIO_PORT_B_IDX) ?
	                              `GPIO_TRIG_PIN : `GPIO_ZERO;
	localparam logic [63:0] PID = `GPIO_PERIPH_ID;
	localparam logic [31:0] CID = `GPIO_CELL_ID;

	logic [7:0] pin_data_value;      // data register
	logic [7:0] direction_ctl;       // 1 = output
	logic [7:0] irq_sense_select;    // 1 = level
	logic [7:0] irq_both_edges;      // 1 = either edge
	logic [7:0] irq_event_polarity;  // 1 = high or rising
	logic [7:0] irq_mask;            // 1 = passes to the line
	logic [7:0] alt_function_select; // 1 = peripheral owns pin
	logic [7:0] drive_2ma_select;    // drive strength, one-hot
	logic [7:0] drive_4ma_select;
	logic [7:0] drive_8ma_select;
	logic [7:0] open_drain_ctl;      // 1 = drive low only
	logic [7:0] pull_up_ctl;         // pull-up resistor
	logic [7:0] pull_down_ctl;       // pull-down resistor
	logic [7:0] slew_limit_ctl;      // slew-rate limiting
	logic [7:0] digital_enable_ctl;  // digital input/output on
	logic       commit_unlocked;     // lock opened by key
	logic [7:0] commit_enable;       // per-pin commit permission
	logic [7:0] pin_sync_val;        // synchronised pad levels
	logic [7:0] irq_raw_status;      // conditions met
	logic [7:0] irq_masked_status;   // conditions allowed through
	logic [7:0] irq_event;           // condition firing this cycle
	logic [7:0] irq_clear;           // clear pulse vector
	logic       wr;                  // write strobe
	logic [7:0] af_allow;            // alternate bits open to write
	logic [7:0] next_rdata;          // read mux result
	logic [7:0] drv_out;             // pin value before pad flop
	logic [7:0] drv_oe;              // enable before pad flop

	// merge a write: only bits in the mask and with a pad change
	function automatic logic [7:0] merge(input logic [7:0] old,
	                                     input logic [7:0] nv,
	                                     input logic [7:0] m);
		return (old & ~(m & PRES)) | (nv & m & PRES);
	endfunction

	// byte lane picker for identification values
	function automatic logic [7:0] id_byte(input logic [63:0] v,
	                                       input logic [2:0] i);
		return v[{i, 3'b000} +: 8];
	endfunction

	assign wr = req_i.valid & req_i.write;

	// inputs are synchronised before any use
	pin_sync u_sync (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.async_i (pad_in_i),
		.sync_o  (pin_sync_val)
	);

	// clear pulses come only from writes of ones
	always_comb begin
		if (wr && req_i.target == gpio_port_pkg::SEL_ICR) begin
			irq_clear = req_i.wdata;
		end else begin
			irq_clear = 8'h00;
		end
	end

	// interrupt condition detection per pin
	irq_detect u_irq (
		.clk_i   (clk_i),
		.rstn_i  (rstn_i),
		.pin_i   (pin_sync_val),
		.sense_i (irq_sense_select),
		.both_i  (irq_both_edges),
		.pol_i   (irq_event_polarity),
		.clear_i (irq_clear),
		.raw_o   (irq_raw_status),
		.event_o (irq_event)
	);

	// masked status is the raw status gated by the mask
	assign irq_masked_status = irq_raw_status & irq_mask & PRES;

	// port line and converter trigger, registered
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			irq_o  <= 1'b0;
			trig_o <= 1'b0;
		end else begin
			irq_o  <= |irq_masked_status;
			// one pulse per edge on an unmasked pin; high every cycle a level condition holds
			trig_o <= |(irq_event & irq_mask & TRIG);
		end
	end

	// data register: inputs capture the pin, outputs hold writes
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			pin_data_value <= 8'h00;
		end else begin
			if (wr && req_i.target == gpio_port_pkg::SEL_DATA) begin
				// address bits act as a per-bit write mask
				pin_data_value <= (merge(pin_data_value, req_i.wdata,
				                         req_i.addr_mask) & direction_ctl)
				                | (pin_sync_val & ~direction_ctl & PRES);
			end else begin
				pin_data_value <= (pin_data_value & direction_ctl)
				                | (pin_sync_val & ~direction_ctl & PRES);
			end
		end
	end

	// direction and interrupt settings
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			direction_ctl      <= 8'h00;
			irq_sense_select   <= 8'h00;
			irq_both_edges     <= 8'h00;
			irq_event_polarity <= 8'h00;
			irq_mask           <= 8'h00;
		end else if (wr) begin
			// a write here while unmasked may raise a spurious event
			case (req_i.target)
				gpio_port_pkg::SEL_DIR:
					direction_ctl <= merge(direction_ctl, req_i.wdata,
					                       `GPIO_ONES);
				gpio_port_pkg::SEL_IS:
					irq_sense_select <= merge(irq_sense_select,
					                          req_i.wdata, `GPIO_ONES);
				gpio_port_pkg::SEL_IBE:
					irq_both_edges <= merge(irq_both_edges,
					                        req_i.wdata, `GPIO_ONES);
				gpio_port_pkg::SEL_IEV:
					irq_event_polarity <= merge(irq_event_polarity,
					                            req_i.wdata, `GPIO_ONES);
				gpio_port_pkg::SEL_IM:
					irq_mask <= merge(irq_mask, req_i.wdata, `GPIO_ONES);
				default: begin
				end
			endcase
		end
	end

	// commit lock: the key opens it, any other value shuts it
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			commit_unlocked <= 1'b0;
			commit_enable   <= `GPIO_ONES ^ DBG;
		end else if (wr) begin
			if (req_i.target == gpio_port_pkg::SEL_LOCK) begin
				commit_unlocked <= (req_i.wdata == `GPIO_UNLOCK_KEY);
			end else if (req_i.target == gpio_port_pkg::SEL_CR &&
			             commit_unlocked) begin
				// only the debug bits are writable, others stay one
				commit_enable <= merge(commit_enable, req_i.wdata, DBG);
			end
		end
	end

	// protected bits change only when unlocked and committed
	assign af_allow = ~DBG | (DBG & commit_enable & {8{commit_unlocked}});

	// mode select and the reset-sensitive pad controls
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			// debug pins come back in their debug role
			alt_function_select <= DBG;
			digital_enable_ctl  <= DBG;
			pull_up_ctl         <= DBG;
			pull_down_ctl       <= 8'h00;
		end else if (wr) begin
			if (req_i.target == gpio_port_pkg::SEL_AFSEL) begin
				alt_function_select <= merge(alt_function_select,
				                             req_i.wdata, af_allow);
			end else if (req_i.target == gpio_port_pkg::SEL_DEN) begin
				digital_enable_ctl <= merge(digital_enable_ctl,
				                            req_i.wdata, `GPIO_ONES);
			end else if (req_i.target == gpio_port_pkg::SEL_PUR) begin
				// pull-up and pull-down exclude each other
				pull_up_ctl   <= merge(pull_up_ctl, req_i.wdata,
				                       `GPIO_ONES);
				pull_down_ctl <= pull_down_ctl & ~(req_i.wdata & PRES);
			end else if (req_i.target == gpio_port_pkg::SEL_PDR) begin
				pull_down_ctl <= merge(pull_down_ctl, req_i.wdata,
				                       `GPIO_ONES);
				pull_up_ctl   <= pull_up_ctl & ~(req_i.wdata & PRES);
			end
		end
	end

	// drive strength is one-hot per pin; the rest is plain storage
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			drive_2ma_select <= PRES;
			drive_4ma_select <= 8'h00;
			drive_8ma_select <= 8'h00;
			open_drain_ctl   <= 8'h00;
			slew_limit_ctl   <= 8'h00;
		end else if (wr) begin
			case (req_i.target)
				gpio_port_pkg::SEL_DR2: begin
					drive_2ma_select <= merge(drive_2ma_select,
					                          req_i.wdata, `GPIO_ONES);
					drive_4ma_select <= drive_4ma_select & ~(req_i.wdata & PRES);
					drive_8ma_select <= drive_8ma_select & ~(req_i.wdata & PRES);
				end
				gpio_port_pkg::SEL_DR4: begin
					drive_4ma_select <= merge(drive_4ma_select,
					                          req_i.wdata, `GPIO_ONES);
					drive_2ma_select <= drive_2ma_select & ~(req_i.wdata & PRES);
					drive_8ma_select <= drive_8ma_select & ~(req_i.wdata & PRES);
				end
				gpio_port_pkg::SEL_DR8: begin
					drive_8ma_select <= merge(drive_8ma_select,
					                          req_i.wdata, `GPIO_ONES);
					drive_2ma_select <= drive_2ma_select & ~(req_i.wdata & PRES);
					drive_4ma_select <= drive_4ma_select & ~(req_i.wdata & PRES);
				end
				gpio_port_pkg::SEL_ODR:
					open_drain_ctl <= merge(open_drain_ctl, req_i.wdata,
					                        `GPIO_ONES);
				gpio_port_pkg::SEL_SLR:
					slew_limit_ctl <= merge(slew_limit_ctl, req_i.wdata,
					                        `GPIO_ONES);
				default: begin
				end
			endcase
		end
	end

	// pin owner select: peripheral or data register
	always_comb begin
		drv_out = (alt_function_select & periph_i.out)
		        | (~alt_function_select & pin_data_value);
		drv_oe  = (alt_function_select & periph_i.oe)
		        | (~alt_function_select & direction_ctl);
		// open drain only ever pulls low
		drv_oe  = (drv_oe & ~open_drain_ctl)
		        | (drv_oe & open_drain_ctl & ~drv_out);
		drv_out = drv_out & ~open_drain_ctl;
		// no drive without digital enable or a pad
		drv_oe  = drv_oe & digital_enable_ctl & PRES;
	end

	// pad outputs are registered so the pads see clean levels
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			// pads see the debug role during reset, not just after it
			pad_o <= '{den: DBG, pur: DBG, dr2: PRES, default: 8'h00};
		end else begin
			pad_o.out <= drv_out;
			pad_o.oe  <= drv_oe;
			pad_o.den <= digital_enable_ctl;
			pad_o.pur <= pull_up_ctl;
			pad_o.pdr <= pull_down_ctl;
			pad_o.odr <= open_drain_ctl;
			pad_o.slr <= slew_limit_ctl;
			pad_o.dr2 <= drive_2ma_select;
			pad_o.dr4 <= drive_4ma_select;
			pad_o.dr8 <= drive_8ma_select;
		end
	end

	// peripherals sample the synchronised pin of their own pins
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			periph_in_o <= 8'h00;
		end else begin
			periph_in_o <= pin_sync_val & alt_function_select
			             & digital_enable_ctl;
		end
	end

	// read mux
	always_comb begin
		next_rdata = 8'h00;
		if (req_i.target == gpio_port_pkg::SEL_DATA) begin
			next_rdata = pin_data_value & req_i.addr_mask;
		end else if (req_i.target == gpio_port_pkg::SEL_DIR) begin
			next_rdata = direction_ctl;
		end else if (req_i.target == gpio_port_pkg::SEL_IS) begin
			next_rdata = irq_sense_select;
		end else if (req_i.target == gpio_port_pkg::SEL_IBE) begin
			next_rdata = irq_both_edges;
		end else if (req_i.target == gpio_port_pkg::SEL_IEV) begin
			next_rdata = irq_event_polarity;
		end else if (req_i.target == gpio_port_pkg::SEL_IM) begin
			next_rdata = irq_mask;
		end else if (req_i.target == gpio_port_pkg::SEL_RIS) begin
			next_rdata = irq_raw_status & PRES;
		end else if (req_i.target == gpio_port_pkg::SEL_MIS) begin
			next_rdata = irq_masked_status;
		end else if (req_i.target == gpio_port_pkg::SEL_AFSEL) begin
			next_rdata = alt_function_select;
		end else if (req_i.target == gpio_port_pkg::SEL_DR2) begin
			next_rdata = drive_2ma_select;
		end else if (req_i.target == gpio_port_pkg::SEL_DR4) begin
			next_rdata = drive_4ma_select;
		end else if (req_i.target == gpio_port_pkg::SEL_DR8) begin
			next_rdata = drive_8ma_select;
		end else if (req_i.target == gpio_port_pkg::SEL_ODR) begin
			next_rdata = open_drain_ctl;
		end else if (req_i.target == gpio_port_pkg::SEL_PUR) begin
			next_rdata = pull_up_ctl;
		end else if (req_i.target == gpio_port_pkg::SEL_PDR) begin
			next_rdata = pull_down_ctl;
		end else if (req_i.target == gpio_port_pkg::SEL_SLR) begin
			next_rdata = slew_limit_ctl;
		end else if (req_i.target == gpio_port_pkg::SEL_DEN) begin
			next_rdata = digital_enable_ctl;
		end else if (req_i.target == gpio_port_pkg::SEL_LOCK) begin
			next_rdata = commit_unlocked ? `GPIO_LOCK_OPEN
			                             : `GPIO_LOCK_SHUT;
		end else if (req_i.target == gpio_port_pkg::SEL_CR) begin
			next_rdata = commit_enable;
		end else if (req_i.target == gpio_port_pkg::SEL_PID) begin
			next_rdata = id_byte(PID, req_i.addr_mask[2:0]);
		end else if (req_i.target == gpio_port_pkg::SEL_CID) begin
			// cell ident uses the low four lanes only
			next_rdata = id_byte({32'h00000000, CID},
			                     {1'b0, req_i.addr_mask[1:0]});
		end
	end

	// every request is answered one cycle later; writes read zero
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			rsp_o <= '0;
		end else begin
			rsp_o.valid <= req_i.valid;
			rsp_o.rdata <= (req_i.valid && !req_i.write) ? next_rdata
			                                             : 8'h00;
		end
	end
endmodule

// the bank: seven copies of the same port
module gpio_port_bank (
	input  wire logic                         clk_i,
	input  wire logic                         rstn_i,
	input  wire gpio_port_pkg::acc_req_s [6:0] acc_req_i,
	output gpio_port_pkg::acc_rsp_s      [6:0] acc_rsp_o,
	input  wire logic [6:0][7:0]              pad_in_i,
	output gpio_port_pkg::pad_ctl_s      [6:0] pad_o,
	input  wire gpio_port_pkg::periph_s  [6:0] periph_i,
	output logic      [6:0][7:0]              periph_in_o,
	output logic      [6:0]                   port_irq_o,
	output logic                              converter_trigger_o
);
	logic [6:0] trig; // per-port trigger, only port B can fire

	// one instance per port, index picks its masks
	for (genvar p = 0; p < `GPIO_PORT_COUNT; p++) begin : g_port
		gpio_port_core #(
			.PORT_IDX (p)
		) u_port (
			.clk_i       (clk_i),
			.rstn_i      (rstn_i),
			.req_i       (acc_req_i[p]),
			.rsp_o       (acc_rsp_o[p]),
			.pad_in_i    (pad_in_i[p]),
			.pad_o       (pad_o[p]),
			.periph_i    (periph_i[p]),
			.periph_in_o (periph_in_o[p]),
			.irq_o       (port_irq_o[p]),
			.trig_o      (trig[p])
		);
	end

	assign converter_trigger_o = trig[`GPIO_PORT_B_IDX];
endmodule

// ==== rtl/irq_detect.sv ====
`timescale 1ns/1ps
// per-pin interrupt condition detection and edge latching
module irq_detect (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] pin_i,
	input  wire logic [7:0] sense_i,
	input  wire logic [7:0] both_i,
	input  wire logic [7:0] pol_i,
	input  wire logic [7:0] clear_i,
	output logic      [7:0] raw_o,
	output logic      [7:0] event_o
);
	logic [7:0] prev;      // pin level one cycle ago
	logic [7:0] latched;   // sticky edge conditions
	logic [7:0] rise;      // rising edges this cycle
	logic [7:0] fall;      // falling edges this cycle
	logic [7:0] edge_hit;  // selected edge seen
	logic [7:0] level_hit; // selected level present

	// decode the three settings per pin
	always_comb begin
		rise      = pin_i & ~prev;
		fall      = ~pin_i & prev;
		edge_hit  = both_i & (rise | fall)
		          | ~both_i & pol_i & rise
		          | ~both_i & ~pol_i & fall;
		level_hit = (pin_i & pol_i) | (~pin_i & ~pol_i);
		// level pins follow the pin, edge pins stay latched
		raw_o     = (sense_i & level_hit) | (~sense_i & latched);
		event_o   = (sense_i & level_hit) | (~sense_i & edge_hit);
	end

	// edge latch: a new edge wins over a clear in the same cycle
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			prev    <= 8'h00;
			latched <= 8'h00;
		end else begin
			prev    <= pin_i;
			latched <= (latched & ~clear_i) | (~sense_i & edge_hit);
		end
	end
endmodule

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ps
// two-flop synchroniser for the pad inputs
module pin_sync (
	input  wire logic       clk_i,
	input  wire logic       rstn_i,
	input  wire logic [7:0] async_i,
	output logic      [7:0] sync_o
);
	logic [7:0] stage1;  // metastable stage, read only by stage two

	// both stages clear on reset
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			stage1 <= 8'h00;
			sync_o <= 8'h00;
		end else begin
			stage1 <= async_i;
			sync_o <= stage1;
		end
	end
endmodule

// ==== shared/gpio_port_pkg.sv ====
package gpio_port_pkg;
	`include "gpio_port_regs.svh"

	// register select of the access port
	typedef enum logic [4:0] {
		SEL_DATA   = 5'h00,
		SEL_DIR    = 5'h01,
		SEL_IS     = 5'h02,
		SEL_IBE    = 5'h03,
		SEL_IEV    = 5'h04,
		SEL_IM     = 5'h05,
		SEL_RIS    = 5'h06,
		SEL_MIS    = 5'h07,
		SEL_ICR    = 5'h08,
		SEL_AFSEL  = 5'h09,
		SEL_DR2    = 5'h0A,
		SEL_DR4    = 5'h0B,
		SEL_DR8    = 5'h0C,
		SEL_ODR    = 5'h0D,
		SEL_PUR    = 5'h0E,
		SEL_PDR    = 5'h0F,
		SEL_SLR    = 5'h10,
		SEL_DEN    = 5'h11,
		SEL_LOCK   = 5'h12,
		SEL_CR     = 5'h13,
		SEL_PID    = 5'h14,
		SEL_CID    = 5'h15
	} reg_sel_e;

	// one register access request
	typedef struct packed {
		logic           valid;
		logic           write;
		reg_sel_e       target;
		logic [7:0]     addr_mask;
		logic [7:0]     wdata;
	} acc_req_s;

	// answer to a request, one cycle later
	typedef struct packed {
		logic           valid;
		logic [7:0]     rdata;
	} acc_rsp_s;

	// peripheral drive toward the pins
	typedef struct packed {
		logic [7:0]     out;
		logic [7:0]     oe;
	} periph_s;

	// everything the pad cells of one port receive
	typedef struct packed {
		logic [7:0]     out;
		logic [7:0]     oe;
		logic [7:0]     den;
		logic [7:0]     pur;
		logic [7:0]     pdr;
		logic [7:0]     odr;
		logic [7:0]     slr;
		logic [7:0]     dr2;
		logic [7:0]     dr4;
		logic [7:0]     dr8;
	} pad_ctl_s;

	// debug pins of a port
	function automatic logic [7:0] debug_mask_of(input int idx);
		if (idx == `GPIO_PORT_B_IDX) begin
			return `GPIO_DBG_MASK_B;
		end else if (idx == `GPIO_PORT_C_IDX) begin
			return `GPIO_DBG_MASK_C;
		end else begin
			return `GPIO_ZERO;
		end
	endfunction

	// pins with a pad attached
	function automatic logic [7:0] present_mask_of(input int idx);
		case (idx)
			0:       return `GPIO_PRESENT_A;
			1:       return `GPIO_PRESENT_B;
			2:       return `GPIO_PRESENT_C;
			3:       return `GPIO_PRESENT_D;
			4:       return `GPIO_PRESENT_E;
			5:       return `GPIO_PRESENT_F;
			default: return `GPIO_PRESENT_G;
		endcase
	endfunction
endpackage

// ==== shared/gpio_port_regs.svh ====
`ifndef GPIO_PORT_REGS_SVH
`define GPIO_PORT_REGS_SVH

// geometry of the bank
`define GPIO_PORT_COUNT   7
`define GPIO_PORT_WIDTH   8
// port indices (A=0 ... G=6)
`define GPIO_PORT_B_IDX   1
`define GPIO_PORT_C_IDX   2
// debug pins: port B pin 7, port C pins 3..0
`define GPIO_DBG_MASK_B   8'h80
`define GPIO_DBG_MASK_C   8'h0F
// pins that have a pad attached, per port
`define GPIO_PRESENT_A    8'hFF
`define GPIO_PRESENT_B    8'hFF
`define GPIO_PRESENT_C    8'h7F
`define GPIO_PRESENT_D    8'hFF
`define GPIO_PRESENT_E    8'h0F
`define GPIO_PRESENT_F    8'h0F
`define GPIO_PRESENT_G    8'h03
// converter trigger pin inside port B (pin 4)
`define GPIO_TRIG_PIN     8'h10
// key that opens the commit lock
`define GPIO_UNLOCK_KEY   8'hA5
// commit lock read-back values
`define GPIO_LOCK_OPEN    8'h00
`define GPIO_LOCK_SHUT    8'h01
// all-zero and all-one bytes
`define GPIO_ZERO         8'h00
`define GPIO_ONES         8'hFF
// identification bytes: arbitrary values
`define GPIO_PERIPH_ID    64'h0807060504030201
`define GPIO_CELL_ID      32'h44332211

`endif
